// ==== src/wake_pin_flags_upper.sv ====
// Purpose: Upper wake pin flag register with AHB-Lite access and interrupt.
// Assumes: rst_n is the chip reset that excludes deep stop wake.
// Notes:   Zero wait states; read data is registered in the address phase.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
module wake_pin_flags_upper (
  // Clock and chip reset
  input  wire logic                           clk_sys,
  input  wire logic                           rst_n,
  // Deep stop wake reset, synchronous, leaves flags alone
  input  wire logic                           deepStopWakeRst,
  // Power mode levels from the mode controller
  input  wire logic                           lowLeakStop,
  input  wire logic                           veryLowLeakStop,
  // Wake pins 8 to 15 and their enables
  input  wire logic [wpfu_pkg::NUM_FLAGS-1:0] wakePinRaw,
  input  wire logic [wpfu_pkg::NUM_FLAGS-1:0] wakePinEnableSetting,
  // AHB-Lite slave
  input  wire logic                           hsel,
  input  wire logic [wpfu_pkg::ADDR_W-1:0]    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [wpfu_pkg::DATA_W-1:0]    hwdata,
  input  wire logic                           hready,
  output logic                                hreadyout,
  output logic      [wpfu_pkg::DATA_W-1:0]    hrdata,
  output logic                                hresp,
  // Wake flows and interrupt
  output logic                                cpuWakeFlowPulse,
  output logic                                resetWakeFlowPulse,
  output logic                                wakeIrq
);

  localparam int unsigned NF = wpfu_pkg::NUM_FLAGS;

  // Word-aligned address decode, shared by read and write paths
  function automatic wpfu_pkg::wpfu_sel_type decodeSel(
    input logic [wpfu_pkg::ADDR_W-1:0] addr
  );
    logic [wpfu_pkg::ADDR_W-1:0] word;
    word = addr & wpfu_pkg::WORD_MASK;
    if (word == wpfu_pkg::FLAGS_ADDR) begin
      decodeSel = wpfu_pkg::SEL_FLAGS;
    end else if (word == wpfu_pkg::STAT_ADDR) begin
      decodeSel = wpfu_pkg::SEL_STAT;
    end else if (word == wpfu_pkg::MASK_ADDR) begin
      decodeSel = wpfu_pkg::SEL_MASK;
    end else begin
      decodeSel = wpfu_pkg::SEL_NONE;
    end
  endfunction

  logic [NF-1:0]                 pinQualified;
  wpfu_pkg::wpfu_mode_type       mode_q;
  wpfu_pkg::wpfu_mode_type       mode_d;
  logic [NF-1:0]                 flags_q;
  logic [NF-1:0]                 flags_d;
  logic [NF-1:0]                 stat_q;
  logic [NF-1:0]                 stat_d;
  logic [NF-1:0]                 mask_q;
  logic [NF-1:0]                 mask_d;
  logic                          wrPend_q;
  logic                          wrPend_d;
  wpfu_pkg::wpfu_sel_type        wrSel_q;
  wpfu_pkg::wpfu_sel_type        wrSel_d;
  logic [wpfu_pkg::DATA_W-1:0]   rdata_q;
  logic [wpfu_pkg::DATA_W-1:0]   rdata_d;
  logic                          cpuFlow_q;
  logic                          cpuFlow_d;
  logic                          rstFlow_q;
  logic                          rstFlow_d;
  logic                          irq_q;
  logic                          irq_d;
  logic                          inStop;
  logic                          wakeHit;
  logic [NF-1:0]                 setVec;
  logic [NF-1:0]                 clrMask;
  logic                          acceptAddr;
  logic                          acceptRead;
  wpfu_pkg::wpfu_sel_type        addrSel;

  // Pin synchroniser and enable gating
  wpfu_pin_qualify u_qualify (
    .clk_sys              (clk_sys),
    .rst_n                (rst_n),
    .wakePinRaw           (wakePinRaw),
    .wakePinEnableSetting (wakePinEnableSetting),
    .pinQualified         (pinQualified)
  );

  // Wake qualification: a pin counts only while a stop mode is held
  always_comb begin
    inStop  = (mode_q == wpfu_pkg::MODE_LOW_LEAK_STOP) ||
              (mode_q == wpfu_pkg::MODE_VERY_LOW_LEAK_STOP);
    wakeHit = inStop && (|pinQualified) && !deepStopWakeRst;
    setVec  = wakeHit ? pinQualified : '0;
  end

  // Power mode tracker; an exit without a pin sets nothing
  always_comb begin
    mode_d    = mode_q;
    cpuFlow_d = 1'b0;
    rstFlow_d = 1'b0;
    case (mode_q)
      wpfu_pkg::MODE_RUN: begin
        if (veryLowLeakStop) begin
          mode_d = wpfu_pkg::MODE_VERY_LOW_LEAK_STOP;
        end else if (lowLeakStop) begin
          mode_d = wpfu_pkg::MODE_LOW_LEAK_STOP;
        end
      end
      wpfu_pkg::MODE_LOW_LEAK_STOP: begin
        if (wakeHit) begin
          cpuFlow_d = 1'b1;
          mode_d    = wpfu_pkg::MODE_RUN;
        end else if (!lowLeakStop) begin
          mode_d = wpfu_pkg::MODE_RUN;
        end
      end
      wpfu_pkg::MODE_VERY_LOW_LEAK_STOP: begin
        if (wakeHit) begin
          rstFlow_d = 1'b1;
          mode_d    = wpfu_pkg::MODE_RUN;
        end else if (!veryLowLeakStop) begin
          mode_d = wpfu_pkg::MODE_RUN;
        end
      end
      default: begin
        mode_d = wpfu_pkg::MODE_RUN;
      end
    endcase
    // Deep stop wake reset restarts the tracker only
    if (deepStopWakeRst) begin
      mode_d    = wpfu_pkg::MODE_RUN;
      cpuFlow_d = 1'b0;
      rstFlow_d = 1'b0;
    end
  end

  // Bus decode; only whole-word transfers touch a register
  always_comb begin
    acceptAddr = hsel && hready && htrans[1] && (hsize == wpfu_pkg::HSIZE_WORD);
    acceptRead = acceptAddr && !hwrite;
    addrSel    = decodeSel(haddr);
    wrPend_d   = acceptAddr && hwrite;
    wrSel_d    = wrPend_d ? addrSel : wpfu_pkg::SEL_NONE;
  end

  // Flag, mask and status next values; hardware set beats a clear
  always_comb begin
    clrMask = (wrPend_q && (wrSel_q == wpfu_pkg::SEL_FLAGS)) ?
              hwdata[NF-1:0] : '0;
    flags_d = (flags_q & ~clrMask) | setVec;
    mask_d  = (wrPend_q && (wrSel_q == wpfu_pkg::SEL_MASK)) ?
              hwdata[NF-1:0] : mask_q;
    stat_d  = ((acceptRead && (addrSel == wpfu_pkg::SEL_STAT)) ?
               '0 : stat_q) | setVec;
    irq_d   = |(stat_d & mask_d);
  end

  // Read mux forwards a write still in its data phase
  always_comb begin
    rdata_d = wpfu_pkg::RDATA_RST;
    if (acceptRead) begin
      case (addrSel)
        wpfu_pkg::SEL_FLAGS: rdata_d[NF-1:0] = flags_d;
        wpfu_pkg::SEL_STAT:  rdata_d[NF-1:0] = stat_q;
        wpfu_pkg::SEL_MASK:  rdata_d[NF-1:0] = mask_d;
        default:             rdata_d = wpfu_pkg::RDATA_RST;
      endcase
    end
  end

  // Of the two resets, only the chip reset clears the flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q    <= wpfu_pkg::MODE_RUN;
      flags_q   <= wpfu_pkg::FLAGS_RST;
      stat_q    <= wpfu_pkg::STAT_RST;
      mask_q    <= wpfu_pkg::MASK_RST;
      wrPend_q  <= 1'b0;
      wrSel_q   <= wpfu_pkg::SEL_NONE;
      rdata_q   <= wpfu_pkg::RDATA_RST;
      cpuFlow_q <= 1'b0;
      rstFlow_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      flags_q   <= flags_d;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      wrPend_q  <= wrPend_d;
      wrSel_q   <= wrSel_d;
      rdata_q   <= rdata_d;
      cpuFlow_q <= cpuFlow_d;
      rstFlow_q <= rstFlow_d;
      irq_q     <= irq_d;
    end
  end

  // Ready flop resets high; the slave never inserts wait states
  logic readyOut_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      readyOut_q <= 1'b1;
    end else begin
      readyOut_q <= 1'b1;
    end
  end

  assign hreadyout          = readyOut_q;
  assign hrdata             = rdata_q;
  assign hresp              = wpfu_pkg::HRESP_OKAY;
  assign cpuWakeFlowPulse   = cpuFlow_q;
  assign resetWakeFlowPulse = rstFlow_q;
  assign wakeIrq            = irq_q;

  // Checks on flag, exit flow and interrupt behaviour
  sequence s_llExit;
    (mode_q == wpfu_pkg::MODE_LOW_LEAK_STOP) && wakeHit;
  endsequence

  sequence s_vllExit;
    (mode_q == wpfu_pkg::MODE_VERY_LOW_LEAK_STOP) && wakeHit;
  endsequence

  sequence s_onePulseCpu;
    cpuWakeFlowPulse && !resetWakeFlowPulse ##1 !cpuWakeFlowPulse;
  endsequence

  sequence s_onePulseRst;
    resetWakeFlowPulse && !cpuWakeFlowPulse ##1 !resetWakeFlowPulse;
  endsequence

  property p_set_on_wake;
    @(posedge clk_sys) disable iff (!rst_n)
    (|setVec) |=> ((flags_q & $past(setVec)) == $past(setVec));
  endproperty
  a_set_on_wake: assert property (p_set_on_wake)
    else $error("wake pin did not set its flag");

  property p_set_only_cause;
    @(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> ((flags_q & ~$past(flags_q) & ~$past(setVec)) == '0);
  endproperty
  a_set_only_cause: assert property (p_set_only_cause)
    else $error("flag set without a qualified wake");

  property p_cpu_flow;
    @(posedge clk_sys) disable iff (!rst_n)
    s_llExit |=> (flags_q != '0) ##0 s_onePulseCpu;
  endproperty
  a_cpu_flow: assert property (p_cpu_flow)
    else $error("low leakage exit missed interrupt flow");

  property p_reset_flow;
    @(posedge clk_sys) disable iff (!rst_n)
    s_vllExit |=> (flags_q != '0) ##0 s_onePulseRst;
  endproperty
  a_reset_flow: assert property (p_reset_flow)
    else $error("very low leakage exit missed reset flow");

  property p_w1c;
    @(posedge clk_sys) disable iff (!rst_n)
    (clrMask != '0) |=> ((flags_q & $past(clrMask) & ~$past(setVec)) == '0);
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write of one did not clear flag");

  property p_sticky;
    @(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> (($past(flags_q) & ~flags_q & ~$past(clrMask)) == '0);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without a clearing write");

  property p_deep_keep;
    @(posedge clk_sys) disable iff (!rst_n)
    (deepStopWakeRst && (clrMask == '0)) |=>
      (flags_q == $past(flags_q)) && (mode_q == wpfu_pkg::MODE_RUN);
  endproperty
  a_deep_keep: assert property (p_deep_keep)
    else $error("deep stop wake reset altered flags");

  property p_zero_write;
    @(posedge clk_sys) disable iff (!rst_n)
    (wrPend_q && (wrSel_q == wpfu_pkg::SEL_FLAGS) && (hwdata[NF-1:0] == '0))
      |=> (flags_q == ($past(flags_q) | $past(setVec)));
  endproperty
  a_zero_write: assert property (p_zero_write)
    else $error("zero write changed a flag");

  property p_readback;
    @(posedge clk_sys) disable iff (!rst_n)
    (acceptRead && (addrSel == wpfu_pkg::SEL_FLAGS)) |=>
      (hrdata[NF-1:0] == flags_q) && (hrdata[wpfu_pkg::DATA_W-1:NF] == '0);
  endproperty
  a_readback: assert property (p_readback)
    else $error("flag readback wrong");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_n)
    // Mask write in the set cycle counts; later level follows status and mask
    (|(setVec & mask_d)) |=>
      wakeIrq ##1 (wakeIrq == (|(stat_q & mask_q)));
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked wake event raised no interrupt");

endmodule

// ==== src/wpfu_pin_qualify.sv ====
// Purpose: Bring the upper wake pins into clk_sys and gate them by enable.
// Assumes: Pins are asynchronous; enable settings come from clk_sys logic.
// Notes:   Three cycles from a pin edge to the qualified output.
`timescale 1ns/10ps
module wpfu_pin_qualify (
  // Clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           rst_n,
  // Pins and enables
  input  wire logic [wpfu_pkg::NUM_FLAGS-1:0] wakePinRaw,
  input  wire logic [wpfu_pkg::NUM_FLAGS-1:0] wakePinEnableSetting,
  // Qualified wake requests
  output logic      [wpfu_pkg::NUM_FLAGS-1:0] pinQualified
);

  logic [wpfu_pkg::NUM_FLAGS-1:0] syncA_q;
  logic [wpfu_pkg::NUM_FLAGS-1:0] syncB_q;
  logic [wpfu_pkg::NUM_FLAGS-1:0] qual_q;
  logic [wpfu_pkg::NUM_FLAGS-1:0] qual_d;

  // Gate only after the second stage; first stage feeds nothing else
  always_comb begin
    qual_d = syncB_q & wakePinEnableSetting;
  end

  // Two-stage synchroniser and registered output
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q <= wpfu_pkg::FLAGS_RST;
      syncB_q <= wpfu_pkg::FLAGS_RST;
      qual_q  <= wpfu_pkg::FLAGS_RST;
    end else begin
      syncA_q <= wakePinRaw;
      syncB_q <= syncA_q;
      qual_q  <= qual_d;
    end
  end

  assign pinQualified = qual_q;

endmodule

// ==== src/wpfu_pkg.sv ====
// Purpose: Constants, register map and types for the upper wake pin flags.
// Assumes: AHB-Lite slave with 32-bit data, one clock clk_sys at 200 MHz.
// Notes:   Flag register index 6, byte address is four times the index.
package wpfu_pkg;

  // Widths
  localparam int unsigned NUM_FLAGS = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned PIN_BASE  = 8;   // Bit 0 is wake pin 8

  // Register indices and byte addresses
  localparam logic [ADDR_W-1:0] FLAGS_IDX  = 8'h06;
  localparam logic [ADDR_W-1:0] FLAGS_ADDR = 8'h18;   // Four times FLAGS_IDX
  localparam logic [ADDR_W-1:0] STAT_ADDR  = 8'h20;
  localparam logic [ADDR_W-1:0] MASK_ADDR  = 8'h24;
  localparam logic [ADDR_W-1:0] WORD_MASK  = 8'hfc;

  // Reset values
  localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 8'h00;
  localparam logic [NUM_FLAGS-1:0] STAT_RST  = 8'h00;
  localparam logic [NUM_FLAGS-1:0] MASK_RST  = 8'h00;
  localparam logic [DATA_W-1:0]    RDATA_RST = 32'h0000_0000;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // Register select codes
  typedef enum logic [1:0] {
    SEL_NONE  = 2'h0,
    SEL_FLAGS = 2'h1,
    SEL_STAT  = 2'h2,
    SEL_MASK  = 2'h3
  } wpfu_sel_type;

  // Power mode tracker, one-hot
  typedef enum logic [2:0] {
    MODE_RUN                = 3'h1,
    MODE_LOW_LEAK_STOP      = 3'h2,
    MODE_VERY_LOW_LEAK_STOP = 3'h4
  } wpfu_mode_type;

endpackage

// ==== tb/tb_wake_pin_flags_upper.sv ====
// Purpose: Self-checking bench for the upper wake pin flag register.
// Assumes: Zero wait state AHB-Lite slave, one clock at 200 MHz.
// Notes:   Tests run in order; the flag state carries from one to the next.
`timescale 1ns/10ps
module tb_wake_pin_flags_upper;
  logic        clk_sys, rst_n, deepStopWakeRst;
  logic        lowLeakStop, veryLowLeakStop;
  logic [7:0]  pinReq, wakePinRaw, wakePinEnableSetting, haddr;
  logic        hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic        cpuWakeFlowPulse, resetWakeFlowPulse, wakeIrq;
  int          error_cnt, cmp_count;

  wpfu_pin_model pins (.clk_sys(clk_sys), .pinReq(pinReq),
    .wakePinRaw(wakePinRaw));
  wake_pin_flags_upper uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .deepStopWakeRst(deepStopWakeRst), .lowLeakStop(lowLeakStop),
    .veryLowLeakStop(veryLowLeakStop), .wakePinRaw(wakePinRaw),
    .wakePinEnableSetting(wakePinEnableSetting), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .cpuWakeFlowPulse(cpuWakeFlowPulse),
    .resetWakeFlowPulse(resetWakeFlowPulse), .wakeIrq(wakeIrq));

  // Clock
  always #2.5 clk_sys = ~clk_sys;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One single word transfer; the wait is open, the watchdog bounds it
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    logic rdy;
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= wpfu_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    do begin
      @(negedge clk_sys) rdy = hreadyout;
      @(posedge clk_sys);
    end while (rdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge clk_sys);
      rdy = hreadyout;
      rd  = hrdata;
      @(posedge clk_sys);
    end while (rdy !== 1'b1);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask

  // Enter a mode, raise pins, watch which exit pulse fires
  task automatic wake(input logic [7:0] p, input logic [1:0] mode,
                      input logic [1:0] expPulse, input logic expIrq);
    logic [1:0] seen;
    seen = 2'b00;
    @(posedge clk_sys);
    {veryLowLeakStop, lowLeakStop} <= mode;
    @(posedge clk_sys);
    pinReq <= p;
    repeat (12) begin
      @(negedge clk_sys);
      if (seen == 2'b00 && (cpuWakeFlowPulse || resetWakeFlowPulse)) begin
        seen = {cpuWakeFlowPulse, resetWakeFlowPulse};
        chk(wakeIrq, expIrq);
      end
    end
    @(posedge clk_sys);
    pinReq <= 8'h00;
    {veryLowLeakStop, lowLeakStop} <= 2'b00;
    chk(seen, expPulse);  // Exit flow named
    // Let released pins drain through the syncer before the next entry
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic t_reset();
    rchk(wpfu_pkg::FLAGS_ADDR, 32'h0);  // All clear
    rchk(8'h40, 32'h0);
    chk(hresp, wpfu_pkg::HRESP_OKAY);
    chk(hreadyout, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_low_leak();
    wakePinEnableSetting <= 8'hff;
    wake(8'hff, 2'b00, 2'b00, 1'b0);  // Pins outside stop
    rchk(wpfu_pkg::FLAGS_ADDR, 32'h0);  // No flag
    wakePinEnableSetting <= 8'h81;
    wake(8'hff, 2'b01, 2'b10, 1'b0);
    rchk(wpfu_pkg::FLAGS_ADDR, 32'h81);  // Enabled only
    $display("test low leak done");
  endtask

  task automatic t_sticky();
    wakePinEnableSetting <= 8'h00;
    rchk(wpfu_pkg::FLAGS_ADDR, 32'h81);  // Kept
    rchk(wpfu_pkg::STAT_ADDR, 32'h81);
    wr(wpfu_pkg::FLAGS_ADDR, 32'h0000_0000);
    rchk(wpfu_pkg::FLAGS_ADDR, 32'h81);  // Zeros keep
    wr(wpfu_pkg::FLAGS_ADDR, 32'h0000_0001);
    rchk(wpfu_pkg::FLAGS_ADDR, 32'h80);
    wr(wpfu_pkg::FLAGS_ADDR, 32'hffff_ff80);
    rchk(wpfu_pkg::FLAGS_ADDR, 32'h0);
    $display("test sticky done");
  endtask

  task automatic t_very_low();
    wr(wpfu_pkg::MASK_ADDR, 32'h0000_0004);
    wakePinEnableSetting <= 8'h3c;
    wake(8'h3c, 2'b10, 2'b01, 1'b1);
    @(posedge clk_sys);
    deepStopWakeRst <= 1'b1;
    @(posedge clk_sys);
    deepStopWakeRst <= 1'b0;
    rchk(wpfu_pkg::FLAGS_ADDR, 32'h3c);  // Survives
    rchk(wpfu_pkg::STAT_ADDR, 32'h3c);
    repeat (2) @(negedge clk_sys);
    chk(wakeIrq, 1'b0);
    rchk(wpfu_pkg::MASK_ADDR, 32'h04);
    $display("test very low done");
  endtask

  task automatic t_chip_rst();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk(wpfu_pkg::FLAGS_ADDR, 32'h0);  // Cleared
    rchk(wpfu_pkg::MASK_ADDR, 32'h0);
    chk(wakeIrq, 1'b0);
    $display("test chip reset done");
  endtask

  // Verdict, reached from the main flow or the watchdog
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {deepStopWakeRst, lowLeakStop, veryLowLeakStop, hsel, hwrite} = 5'h00;
    {pinReq, wakePinEnableSetting, haddr} = 24'h00_0000;
    htrans = 2'h0;
    hsize = wpfu_pkg::HSIZE_WORD;
    hwdata = 32'h0000_0000;
    error_cnt = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_low_leak();
    t_sticky();
    t_very_low();
    t_chip_rst();
    conclude();
  end

  // Watchdog, far beyond the roughly 130 cycles the tests need
  initial begin
    repeat (4000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
endmodule

// ==== tb/wpfu_pin_model.sv ====
// Purpose: Model of the external wake pins 8 to 15.
// Assumes: Pins idle low through a pull-down when no event is driven.
// Notes:   Edges land 1.3 ns after clk_sys, so the syncer sees them async.
`timescale 1ns/10ps
module wpfu_pin_model (
  // Clock
  input  wire logic       clk_sys,
  // Requested levels, bit n is wake pin n plus eight
  input  wire logic [7:0] pinReq,
  // Pin wires
  output logic      [7:0] wakePinRaw
);
  // Skewed pad update; idle level is the pull-down, never a stale value
  initial wakePinRaw = 8'h00;
  always @(posedge clk_sys) begin
    wakePinRaw <= #1.3 pinReq;  // Bit n drives pin n+8
  end
endmodule
